// [logic/ffmd_axis_cmp.sv]
// one axis: magnitude of a signed sample compared against an unsigned threshold
`timescale 1ns/1ps
module ffmd_axis_cmp #(
    parameter int SW = 14,
    parameter int TW = 13
) (
    // sample and threshold
    input wire logic signed [SW-1:0] sample_i,
    input wire logic [TW-1:0] thresh_i,
    // comparison results
    output logic high_o,
    output logic low_o,
    output logic neg_o
);

    logic [SW-1:0] mag;

    // the most negative code has magnitude 2^(SW-1), still representable unsigned
    always_comb begin
        mag = sample_i[SW-1] ? SW'(-sample_i) : SW'(sample_i);
        high_o = mag > {1'b0, thresh_i};
        low_o = !high_o;
        neg_o = sample_i[SW-1];
    end

endmodule

// [logic/ffmd_detector.sv]
// freefall/motion detector: registers, axis comparison, combination, debounce and event latch
`timescale 1ns/1ps
module ffmd_detector (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register access port
    input wire ffmd_pkg::ffmd_reg_req_t reg_req_i,
    output ffmd_pkg::ffmd_reg_rsp_t reg_rsp_o,
    // acceleration samples
    input wire logic sample_valid_i,
    input wire ffmd_pkg::ffmd_sample_t sample_i,
    // event
    output logic event_active_flag_o
);

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ths;
        logic [7:0] count;
        logic [7:0] ths_x_msb;
        logic [7:0] ths_x_lsb;
        logic [7:0] ths_y_msb;
        logic [7:0] ths_y_lsb;
        logic [7:0] ths_z_msb;
        logic [7:0] ths_z_lsb;
        logic [7:0] dbcnt;
        logic event_active_flag;
        logic [2:0] high_flags;
        logic [2:0] pol_flags;
        logic [7:0] rdata;
        logic rvalid;
    } ffmd_state_t;

    ffmd_state_t state_r;
    ffmd_state_t state_nxt;

    logic [ffmd_pkg::AXES-1:0] axis_en;
    logic per_axis;
    logic [ffmd_pkg::MAG_W-1:0] common_ths;
    logic [ffmd_pkg::MAG_W-1:0] axis_ths [ffmd_pkg::AXES];
    logic signed [ffmd_pkg::SAMPLE_W-1:0] axis_sample [ffmd_pkg::AXES];
    logic [ffmd_pkg::AXES-1:0] high;
    logic [ffmd_pkg::AXES-1:0] low;
    logic [ffmd_pkg::AXES-1:0] neg;
    logic cond;
    logic dbmode_clear;
    logic [7:0] cnt_nxt;
    logic det;
    logic src_read;
    logic [7:0] src_value;

    assign axis_en = {state_r.cfg[ffmd_pkg::CFG_ZEN_BIT],
                      state_r.cfg[ffmd_pkg::CFG_YEN_BIT],
                      state_r.cfg[ffmd_pkg::CFG_XEN_BIT]};
    assign per_axis = state_r.ths_x_msb[ffmd_pkg::THS_XYZ_EN_BIT];
    // the 7-bit common value is aligned with the top of the 13-bit magnitude
    assign common_ths = {state_r.ths[ffmd_pkg::COMMON_W-1:0], {ffmd_pkg::COMMON_SHIFT{1'b0}}};
    assign dbmode_clear = state_r.ths[ffmd_pkg::THS_DBMODE_BIT];

    assign axis_sample[0] = sample_i.x;
    assign axis_sample[1] = sample_i.y;
    assign axis_sample[2] = sample_i.z;

    assign axis_ths[0] = per_axis ? {state_r.ths_x_msb[4:0], state_r.ths_x_lsb} : common_ths;
    assign axis_ths[1] = per_axis ? {state_r.ths_y_msb[4:0], state_r.ths_y_lsb} : common_ths;
    assign axis_ths[2] = per_axis ? {state_r.ths_z_msb[4:0], state_r.ths_z_lsb} : common_ths;

    genvar g;
    generate
        for (g = 0; g < ffmd_pkg::AXES; g = g + 1) begin : gen_axis
            ffmd_axis_cmp #(
                .SW(ffmd_pkg::SAMPLE_W),
                .TW(ffmd_pkg::MAG_W)
            ) u_cmp (
                .sample_i(axis_sample[g]),
                .thresh_i(axis_ths[g]),
                .high_o(high[g]),
                .low_o(low[g]),
                .neg_o(neg[g])
            );
        end
    endgenerate

    // combination; with no axis enabled nothing can trigger
    always_comb begin
        if (state_r.cfg[ffmd_pkg::CFG_LOGIC_BIT]) begin
            cond = |(high & axis_en);
        end else begin
            cond = (axis_en != 3'b000) && (&(low | ~axis_en));
        end
    end

    // debounce counter and its filtered result
    always_comb begin
        cnt_nxt = state_r.dbcnt;
        if (cond) begin
            if (state_r.dbcnt < state_r.count) begin
                cnt_nxt = state_r.dbcnt + 8'h01;
            end
        end else if (dbmode_clear) begin
            cnt_nxt = 8'h00;
        end else if (state_r.dbcnt != 8'h00) begin
            cnt_nxt = state_r.dbcnt - 8'h01;
        end
        // the result drops on the first sample without the condition unless, in decrement mode, the count still reaches a nonzero limit
        if (cond) begin
            det = cnt_nxt >= state_r.count;
        end else begin
            det = !dbmode_clear && (state_r.count != 8'h00) && (cnt_nxt >= state_r.count);
        end
    end

    assign src_read = reg_req_i.rd && (reg_req_i.addr == ffmd_pkg::ADDR_SRC);

    // flags of a disabled axis are masked at read time
    always_comb begin
        src_value = 8'h00;
        src_value[ffmd_pkg::SRC_EA_BIT] = state_r.event_active_flag;
        for (int i = 0; i < ffmd_pkg::AXES; i++) begin
            src_value[2*i+1] = state_r.high_flags[i] & axis_en[i];
            src_value[2*i] = state_r.pol_flags[i] & axis_en[i];
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;

        // register writes
        if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ffmd_pkg::ADDR_CFG: state_nxt.cfg = reg_req_i.wdata & ffmd_pkg::CFG_USED_MASK;
                ffmd_pkg::ADDR_THS: state_nxt.ths = reg_req_i.wdata;
                ffmd_pkg::ADDR_COUNT: state_nxt.count = reg_req_i.wdata;
                ffmd_pkg::ADDR_THS_X_MSB: begin
                    state_nxt.ths_x_msb = reg_req_i.wdata
                        & (ffmd_pkg::THS_MSB_MASK | (8'h01 << ffmd_pkg::THS_XYZ_EN_BIT));
                end
                ffmd_pkg::ADDR_THS_X_LSB: state_nxt.ths_x_lsb = reg_req_i.wdata;
                ffmd_pkg::ADDR_THS_Y_MSB: state_nxt.ths_y_msb = reg_req_i.wdata & ffmd_pkg::THS_MSB_MASK;
                ffmd_pkg::ADDR_THS_Y_LSB: state_nxt.ths_y_lsb = reg_req_i.wdata;
                ffmd_pkg::ADDR_THS_Z_MSB: state_nxt.ths_z_msb = reg_req_i.wdata & ffmd_pkg::THS_MSB_MASK;
                ffmd_pkg::ADDR_THS_Z_LSB: state_nxt.ths_z_lsb = reg_req_i.wdata;
                default: ;
            endcase
        end

        // register reads, answered one cycle later
        if (reg_req_i.rd) begin
            state_nxt.rvalid = 1'b1;
            unique case (reg_req_i.addr)
                ffmd_pkg::ADDR_CFG: state_nxt.rdata = state_r.cfg;
                ffmd_pkg::ADDR_SRC: state_nxt.rdata = src_value;
                ffmd_pkg::ADDR_THS: state_nxt.rdata = state_r.ths;
                ffmd_pkg::ADDR_COUNT: state_nxt.rdata = state_r.count;
                ffmd_pkg::ADDR_THS_X_MSB: state_nxt.rdata = state_r.ths_x_msb;
                ffmd_pkg::ADDR_THS_X_LSB: state_nxt.rdata = state_r.ths_x_lsb;
                ffmd_pkg::ADDR_THS_Y_MSB: state_nxt.rdata = state_r.ths_y_msb;
                ffmd_pkg::ADDR_THS_Y_LSB: state_nxt.rdata = state_r.ths_y_lsb;
                ffmd_pkg::ADDR_THS_Z_MSB: state_nxt.rdata = state_r.ths_z_msb;
                ffmd_pkg::ADDR_THS_Z_LSB: state_nxt.rdata = state_r.ths_z_lsb;
                default: state_nxt.rdata = 8'h00;
            endcase
        end

        // reading the source clears what latching held; an update below in the same cycle wins
        if (src_read && state_r.cfg[ffmd_pkg::CFG_LATCH_BIT]) begin
            state_nxt.event_active_flag = 1'b0;
            state_nxt.high_flags = 3'b000;
            state_nxt.pol_flags = 3'b000;
        end

        if (sample_valid_i) begin
            state_nxt.dbcnt = cnt_nxt;
            if (state_r.cfg[ffmd_pkg::CFG_LATCH_BIT]) begin
                // frozen while the event stays latched and no read releases it
                if (!state_r.event_active_flag || src_read) begin
                    state_nxt.high_flags = high & axis_en;
                    state_nxt.pol_flags = high & neg & axis_en;
                    if (det) begin
                        state_nxt.event_active_flag = 1'b1;
                    end
                end
            end else begin
                state_nxt.event_active_flag = det;
                state_nxt.high_flags = high & axis_en;
                state_nxt.pol_flags = high & neg & axis_en;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= '0;
            state_r.cfg <= ffmd_pkg::CFG_RESET;
            state_r.ths <= ffmd_pkg::THS_RESET;
            state_r.count <= ffmd_pkg::COUNT_RESET;
            state_r.ths_x_msb <= ffmd_pkg::THS_AXIS_RESET;
            state_r.ths_x_lsb <= ffmd_pkg::THS_AXIS_RESET;
            state_r.ths_y_msb <= ffmd_pkg::THS_AXIS_RESET;
            state_r.ths_y_lsb <= ffmd_pkg::THS_AXIS_RESET;
            state_r.ths_z_msb <= ffmd_pkg::THS_AXIS_RESET;
            state_r.ths_z_lsb <= ffmd_pkg::THS_AXIS_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rsp_o.rdata = state_r.rdata;
    assign reg_rsp_o.rvalid = state_r.rvalid;
    assign event_active_flag_o = state_r.event_active_flag;

endmodule

// [logic/ffmd_pkg.sv]
// package: register map, field positions, reset values and carrier types of the freefall/motion detector
package ffmd_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CFG = 8'h15;
    localparam logic [7:0] ADDR_SRC = 8'h16;
    localparam logic [7:0] ADDR_THS = 8'h17;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    localparam logic [7:0] ADDR_THS_X_MSB = 8'h73;
    localparam logic [7:0] ADDR_THS_X_LSB = 8'h74;
    localparam logic [7:0] ADDR_THS_Y_MSB = 8'h75;
    localparam logic [7:0] ADDR_THS_Y_LSB = 8'h76;
    localparam logic [7:0] ADDR_THS_Z_MSB = 8'h77;
    localparam logic [7:0] ADDR_THS_Z_LSB = 8'h78;

    // movement_event_config fields
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_LOGIC_BIT = 6;
    localparam int CFG_ZEN_BIT = 5;
    localparam int CFG_YEN_BIT = 4;
    localparam int CFG_XEN_BIT = 3;
    localparam logic [7:0] CFG_USED_MASK = 8'hf8;

    // movement_event_source fields
    localparam int SRC_EA_BIT = 7;

    // common threshold register fields
    localparam int THS_DBMODE_BIT = 7;
    localparam logic [7:0] THS_VALUE_MASK = 8'h7f;

    // x msb threshold register: per-axis enable and five high threshold bits
    localparam int THS_XYZ_EN_BIT = 7;
    localparam logic [7:0] THS_MSB_MASK = 8'h1f;

    // reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] THS_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] THS_AXIS_RESET = 8'h00;

    // sizes
    localparam int SAMPLE_W = 14;
    localparam int MAG_W = 13;
    localparam int COMMON_W = 7;
    localparam int COMMON_SHIFT = MAG_W - COMMON_W;
    localparam int AXES = 3;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] z;
        logic signed [SAMPLE_W-1:0] y;
        logic signed [SAMPLE_W-1:0] x;
    } ffmd_sample_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ffmd_reg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } ffmd_reg_rsp_t;

endpackage

// [verification/ffmd_properties.sv]
// port-level assertions for the freefall/motion detector
`timescale 1ns/1ps
module ffmd_properties (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire ffmd_pkg::ffmd_reg_req_t reg_req_i,
    input wire ffmd_pkg::ffmd_reg_rsp_t reg_rsp_o,
    input wire logic sample_valid_i,
    input wire ffmd_pkg::ffmd_sample_t sample_i,
    input wire logic event_active_flag_o
);
    // shadow of the config register, rebuilt from writes since the body is not visible
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    always_comb begin
        cfg_nxt = cfg_r;
        if (reg_req_i.wr && reg_req_i.addr == 8'h15) begin
            cfg_nxt = reg_req_i.wdata & ffmd_pkg::CFG_USED_MASK;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_r <= 8'h00;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_src_rd;
        reg_req_i.rd && reg_req_i.addr == 8'h16;
    endsequence
    sequence s_latched;
        cfg_r[7] && event_active_flag_o;
    endsequence
    a_read_answer: assert property (reg_req_i.rd |=> reg_rsp_o.rvalid)
        else $error("read not answered");
    a_no_stray_answer: assert property (reg_rsp_o.rvalid |-> $past(reg_req_i.rd))
        else $error("answer without read");
    a_rdata_stands: assert property (!reg_req_i.rd |=> $stable(reg_rsp_o.rdata))
        else $error("read data moved");
    a_cfg_readback: assert property (reg_req_i.rd && reg_req_i.addr == 8'h15 |=> reg_rsp_o.rdata == $past(cfg_r))
        else $error("config readback wrong");
    a_src_flag_bit: assert property (s_src_rd |=> reg_rsp_o.rdata[7] == $past(event_active_flag_o))
        else $error("source bit 7 differs from flag");
    a_flag_needs_cause: assert property (!sample_valid_i && !reg_req_i.rd && !reg_req_i.wr
        |=> $stable(event_active_flag_o))
        else $error("flag moved without sample");
    a_latch_hold: assert property (s_latched ##0 !reg_req_i.rd |=> event_active_flag_o)
        else $error("latched flag dropped");
    a_latch_clear: assert property (s_latched ##0 s_src_rd ##0 !sample_valid_i |=> !event_active_flag_o)
        else $error("source read did not clear");
    a_none_enabled: assert property (!event_active_flag_o && cfg_r[5:3] == 3'b000 && !reg_req_i.wr
        |=> !event_active_flag_o)
        else $error("event with no axis enabled");
    a_axis_bits: assert property (s_src_rd ##0 !cfg_r[3] |=> reg_rsp_o.rdata[1:0] == 2'b00
        && !reg_rsp_o.rdata[6])
        else $error("disabled axis flags set");
endmodule

bind ffmd_detector ffmd_properties u_props (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i),
    .reg_rsp_o(reg_rsp_o), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .event_active_flag_o(event_active_flag_o));

// [verification/tb.sv]
// self-checking bench for the freefall/motion detector
`timescale 1ns/1ps
module tb;
    logic clk_i;
    logic resetn_i;
    ffmd_pkg::ffmd_reg_req_t req;
    ffmd_pkg::ffmd_reg_rsp_t rsp;
    logic sv;
    ffmd_pkg::ffmd_sample_t smp;
    logic flag;
    int n_errors;
    int n_compared;
    ffmd_detector uut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req), .reg_rsp_o(rsp),
        .sample_valid_i(sv), .sample_i(smp), .event_active_flag_o(flag));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk_i);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int i;
        @(negedge clk_i);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk_i);
        req.rd = 1'b0;
        // rvalid is a one-cycle pulse, so it is polled at every falling edge
        for (i = 0; i < 4 && rsp.rvalid !== 1'b1; i++) @(negedge clk_i);
        if (i == 4) begin
            n_errors++;
            wrap_up();
        end
        chk(rsp.rdata, exp);
    endtask
    // one sample, then the flag is looked at once the update has landed
    task automatic put(input logic e, input logic [13:0] x, input logic [13:0] y = 14'h0,
        input logic [13:0] z = 14'h0);
        @(negedge clk_i);
        smp.x = x;
        smp.y = y;
        smp.z = z;
        sv = 1'b1;
        @(negedge clk_i);
        sv = 1'b0;
        @(negedge clk_i);
        chk({7'h00, flag}, {7'h00, e});
    endtask
    initial begin
        int m;
        int k;
        n_errors = 0;
        n_compared = 0;
        resetn_i = 1'b0;
        req = '0;
        sv = 1'b0;
        smp = '0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        rd(8'h15, 8'h00);
        rd(8'h16, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h15, 8'hff);
        rd(8'h15, 8'hf8);
        // common threshold 1 means a magnitude of 64 after scaling
        wr(8'h17, 8'h01);
        wr(8'h15, 8'h48);
        put(1'b1, 14'd65);
        rd(8'h16, 8'h82);
        put(1'b0, 14'd64);
        put(1'b1, -14'sd65);
        rd(8'h16, 8'h83);
        put(1'b0, 14'h0, 14'd900);
        wr(8'h15, 8'h38);
        put(1'b1, 14'h0);
        rd(8'h16, 8'h80);
        put(1'b0, 14'h0, 14'h0, 14'd65);
        wr(8'h73, 8'hff);
        rd(8'h73, 8'h9f);
        wr(8'h73, 8'h80);
        wr(8'h74, 8'h10);
        wr(8'h15, 8'h48);
        put(1'b1, 14'd17);
        put(1'b0, 14'd16);
        wr(8'h15, 8'hc8);
        put(1'b1, 14'd100);
        put(1'b1, -14'sd100);
        rd(8'h16, 8'h82);
        chk({7'h00, flag}, 8'h00);
        wr(8'h15, 8'h48);
        wr(8'h18, 8'h02);
        // pattern L,L,H,H,L,H: only decrement mode keeps enough count for the last high
        for (m = 0; m < 2; m++) begin
            wr(8'h17, {~m[0], 7'h01});
            for (k = 0; k < 6; k++) put(k == 3 || (k == 5 && m[0]), (8'h2c >> k) & 1 ? 14'd50 : 14'h0);
        end
        // y and z use their own thresholds of 256 and 32; y swings negative, z positive
        wr(8'h18, 8'h00);
        wr(8'h75, 8'h01);
        wr(8'h78, 8'h20);
        wr(8'h15, 8'h78);
        put(1'b1, 14'h0, -14'sd257, 14'sd33);
        rd(8'h16, 8'hac);
        rd(8'h75, 8'h01);
        rd(8'h18, 8'h00);
        // exactly at threshold counts as low-g on both axes
        put(1'b0, 14'h0, 14'd256, 14'd32);
        wrap_up();
    end
endmodule
